// ### scma_target.sv
// target end: decodes address byte, keeps pointer, memory and registers
// assumes scl and sda are asynchronous to sys_clk and are synchronised here
`timescale 1ns/1ps
`include "scma_consts.svh"
module scma_target (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // link
    scma_if.target             bus,
    // straps and control
    input  wire logic          bus_addr_strap_0,
    input  wire logic          bus_addr_strap_1,
    input  wire logic          bus_addr_strap_2,
    input  wire logic          manual_reset_in_n,
    input  wire logic          dev_in_reset,
    input  wire logic          opt_alt_mem_id,
    input  wire logic          opt_reg_wr_any,
    // status
    output logic               nv_busy,
    output logic [7:0]         ptr_out
);
    import scma_pkg::*;
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] scl_s_q, sda_s_q, scl_s_d, sda_s_d;
    logic       scl_p_q, sda_p_q, scl_p_d, sda_p_d;
    logic [2:0] strap_s1_q, strap_s2_q, strap_s1_d, strap_s2_d;
    logic [1:0] mr_s_q, mr_s_d;
    logic       scl_rise, scl_fall, start_ev, stop_ev;
    always_comb begin
        scl_s_d    = {scl_s_q[0], bus.scl};
        sda_s_d    = {sda_s_q[0], bus.sda};
        scl_p_d    = scl_s_q[1];
        sda_p_d    = sda_s_q[1];
        strap_s1_d = {bus_addr_strap_2, bus_addr_strap_1, bus_addr_strap_0};
        strap_s2_d = strap_s1_q;
        mr_s_d     = {mr_s_q[0], manual_reset_in_n};
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s_q    <= 2'h3;
            sda_s_q    <= 2'h3;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            mr_s_q     <= 2'h3;
        end else begin
            scl_s_q    <= scl_s_d;
            sda_s_q    <= sda_s_d;
            scl_p_q    <= scl_p_d;
            sda_p_q    <= sda_p_d;
            strap_s1_q <= strap_s1_d;
            strap_s2_q <= strap_s2_d;
            mr_s_q     <= mr_s_d;
        end
    end
    assign scl_rise = scl_s_q[1] & ~scl_p_q;
    assign scl_fall = ~scl_s_q[1] & scl_p_q;
    assign start_ev = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_ev  = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    // ****************************************
    // storage
    // ****************************************
    // memory commits only at stop, so a page staging array is kept
    logic [7:0] mem_q   [0:`SCMA_MEM_DEPTH-1];
    logic [7:0] cfg_q   [0:`SCMA_REG_COUNT+`SCMA_STAT_COUNT-1];
    logic [7:0] page_q  [0:15];
    // ****************************************
    // protocol engine
    // ****************************************
    typedef enum logic [2:0] {
        SCMA_T_IDLE, SCMA_T_ADDR, SCMA_T_PTR, SCMA_T_WDATA, SCMA_T_RDATA, SCMA_T_ACK,
        SCMA_T_MACK
    } scma_tst_type;
    scma_tst_type state_q, state_d, after_q, after_d;
    logic [7:0]   sh_q, sh_d, ptr_q, ptr_d, base_q, base_d;
    logic [3:0]   bit_q, bit_d;
    logic [4:0]   cnt_q, cnt_d;
    logic         is_reg_q, is_reg_d, drv_q, drv_d, pend_q, pend_d, ptr_new_q, ptr_new_d;
    logic         reg_wr_q, reg_wr_d;
    logic [7:0]   reg_val_q, reg_val_d;
    logic [15:0]  nv_q, nv_d;
    logic [3:0]   nib;
    logic         id_ok, ba_ok, mem_en, reg_en;
    function automatic logic [7:0] rd_byte(input logic r, input logic [7:0] a);
        rd_byte = r ? cfg_q[a[5:0]] : mem_q[a];
    endfunction
    always_comb begin
        // decode runs with all eight address bits in sh_q
        nib    = sh_q[`SCMA_ID_MSB:`SCMA_ID_LSB];
        id_ok  = (nib == `SCMA_ID_REG) ||
                 (nib == (opt_alt_mem_id ? `SCMA_ID_MEM_ALT : `SCMA_ID_MEM));
        ba_ok  = (sh_q[`SCMA_BA_MSB:`SCMA_BA_LSB] == strap_s2_q);
        mem_en = mr_s_q[1] & ~dev_in_reset;
        reg_en = opt_reg_wr_any | ~mr_s_q[1];
        state_d = state_q; after_d = after_q; sh_d = sh_q; ptr_d = ptr_q; base_d = base_q;
        bit_d = bit_q; cnt_d = cnt_q; is_reg_d = is_reg_q; drv_d = drv_q; pend_d = pend_q;
        ptr_new_d = ptr_new_q; reg_wr_d = reg_wr_q; reg_val_d = reg_val_q;
        nv_d = (nv_q != 16'h0000) ? nv_q - 16'h0001 : nv_q;
        if (start_ev) begin
            state_d = SCMA_T_ADDR; bit_d = 4'h0; drv_d = 1'b0;
            // a write cut short by a new start is dropped, never committed
            pend_d = 1'b0;
            reg_wr_d = 1'b0;
        end else if (stop_ev) begin
            state_d = SCMA_T_IDLE; drv_d = 1'b0;
            if (pend_q && cnt_q != 5'h00) begin
                pend_d = 1'b0; nv_d = `SCMA_NV_WAIT;
            end
            pend_d = 1'b0;
            reg_wr_d = 1'b0;
        end else begin
            unique case (state_q)
                SCMA_T_IDLE: ;
                SCMA_T_ADDR, SCMA_T_PTR, SCMA_T_WDATA: if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s_q[1]};
                    bit_d = bit_q + 4'h1;
                end else if (scl_fall && bit_q == 4'h8) begin
                    bit_d = 4'h0;
                    drv_d = 1'b1;
                    if (state_q == SCMA_T_ADDR) begin
                        is_reg_d = (nib == `SCMA_ID_REG);
                        if (!(id_ok && ba_ok)) begin
                            drv_d = 1'b0; state_d = SCMA_T_IDLE;
                        end else if (sh_q[`SCMA_RW_BIT]) begin
                            after_d = SCMA_T_RDATA; state_d = SCMA_T_ACK;
                            // a freshly loaded pointer is read as is
                            ptr_new_d = 1'b0;
                            if (!ptr_new_q)
                                ptr_d = ptr_q + 8'h01;
                        end else begin
                            after_d = SCMA_T_PTR; state_d = SCMA_T_ACK;
                            cnt_d = 5'h00; pend_d = 1'b0;
                        end
                    end else if (state_q == SCMA_T_PTR) begin
                        ptr_d = sh_q; base_d = sh_q; ptr_new_d = 1'b1;
                        after_d = SCMA_T_WDATA; state_d = SCMA_T_ACK;
                    end else begin
                        after_d = SCMA_T_WDATA; state_d = SCMA_T_ACK;
                        if (is_reg_q) begin
                            if (cnt_q == 5'h00 && reg_en) begin
                                reg_wr_d = 1'b1; reg_val_d = sh_q; pend_d = 1'b1;
                            end
                            if (cnt_q == 5'h00) begin
                                cnt_d = 5'h01;
                                ptr_new_d = 1'b0;
                            end
                        end else if (cnt_q <= {1'b0, `SCMA_PAGE_LAST} && mem_en) begin
                            cnt_d = cnt_q + 5'h01; pend_d = 1'b1;
                            ptr_new_d = 1'b0;
                            // pointer holds the last address written
                            ptr_d = {base_q[7:4], base_q[3:0] + cnt_q[3:0]};
                        end
                    end
                end
                SCMA_T_ACK: if (scl_fall) begin
                    drv_d = 1'b0; state_d = after_q;
                    if (after_q == SCMA_T_RDATA) begin
                        sh_d = rd_byte(is_reg_q, ptr_q); drv_d = ~sh_d[7];
                        bit_d = 4'h1;
                    end
                end
                SCMA_T_RDATA: if (scl_fall) begin
                    if (bit_q == 4'h8) begin
                        drv_d = 1'b0; state_d = SCMA_T_MACK; bit_d = 4'h0;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0}; drv_d = ~sh_d[7]; bit_d = bit_q + 4'h1;
                    end
                end
                SCMA_T_MACK: if (scl_rise) begin
                    if (sda_s_q[1] || is_reg_q) begin
                        state_d = SCMA_T_IDLE;
                    end else begin
                        ptr_d = ptr_q + 8'h01; state_d = SCMA_T_ACK;
                        after_d = SCMA_T_RDATA;
                    end
                end
                default: state_d = SCMA_T_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= SCMA_T_IDLE; after_q <= SCMA_T_IDLE; sh_q <= 8'h00; ptr_q <= 8'hff;
            base_q <= 8'h00; bit_q <= 4'h0; cnt_q <= 5'h00; is_reg_q <= 1'b0;
            drv_q <= 1'b0; pend_q <= 1'b0; ptr_new_q <= 1'b0; reg_wr_q <= 1'b0;
            reg_val_q <= 8'h00; nv_q <= 16'h0000;
        end else begin
            state_q <= state_d; after_q <= after_d; sh_q <= sh_d; ptr_q <= ptr_d;
            base_q <= base_d; bit_q <= bit_d; cnt_q <= cnt_d; is_reg_q <= is_reg_d;
            drv_q <= drv_d; pend_q <= pend_d; ptr_new_q <= ptr_new_d; reg_wr_q <= reg_wr_d;
            reg_val_q <= reg_val_d; nv_q <= nv_d;
        end
    end
    // ****************************************
    // array updates (no reset: nonvolatile content)
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (state_q == SCMA_T_WDATA && state_d == SCMA_T_ACK && !is_reg_q &&
            cnt_q <= {1'b0, `SCMA_PAGE_LAST} && mem_en)
            page_q[cnt_q[3:0]] <= sh_q;
        if (stop_ev && pend_q && !is_reg_q)
            for (int i = 0; i < 16; i++)
                if (5'(i) < cnt_q)
                    mem_q[{base_q[7:4], base_q[3:0] + 4'(i)}] <= page_q[i];
        // register value also waits for stop before it lands
        if (stop_ev && reg_wr_q)
            cfg_q[ptr_q[4:0]] <= reg_val_q;
    end
    assign bus.sda_t_o    = 1'b0;
    assign bus.sda_t_oe_n = ~drv_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nv_busy <= 1'b0;
            ptr_out <= 8'h00;
        end else begin
            nv_busy <= (nv_d != 16'h0000);
            ptr_out <= ptr_d;
        end
    end
endmodule

// ### scma_consts.svh
// constants for the serial config memory access link
// assumes inclusion by bare name from scma_target and scma_host
`ifndef SCMA_CONSTS_SVH
`define SCMA_CONSTS_SVH
// ****************************************
// address byte decode
// ****************************************
`define SCMA_ID_MEM        4'ha
`define SCMA_ID_MEM_ALT    4'hb
`define SCMA_ID_REG        4'h9
`define SCMA_ID_MSB        7
`define SCMA_ID_LSB        4
`define SCMA_BA_MSB        3
`define SCMA_BA_LSB        1
`define SCMA_RW_BIT        0
// ****************************************
// sizes and timing
// ****************************************
`define SCMA_PAGE_LAST     4'hf
`define SCMA_MEM_DEPTH     256
`define SCMA_REG_COUNT     32
`define SCMA_STAT_COUNT    8
`define SCMA_SCL_HALF      8'h08
`define SCMA_NV_WAIT       16'h0100
`endif

// ### scma_pkg.sv
// types for the serial config memory access link
// needs nothing from scma_consts.svh; it is not included here
package scma_pkg;
    typedef enum logic [1:0] {
        SCMA_CMD_MWRITE,
        SCMA_CMD_RWRITE,
        SCMA_CMD_MREAD,
        SCMA_CMD_RREAD
    } scma_cmd_type;
    typedef logic [7:0] scma_byte_type;
endpackage

// ### scma_if.sv
// two-wire link between the host end and the target end
// open-drain: wire is low if either side enables its driver
`timescale 1ns/1ps
interface scma_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_h_o;
    logic sda_h_oe_n;
    logic sda_t_o;
    logic sda_t_oe_n;
    logic scl;
    logic sda;
    assign scl = scl_oe_n ? 1'b1 : scl_o;
    assign sda = (sda_h_oe_n ? 1'b1 : sda_h_o) & (sda_t_oe_n ? 1'b1 : sda_t_o);
    modport host   (output scl_o, output scl_oe_n, output sda_h_o, output sda_h_oe_n,
                    input scl, input sda);
    modport target (output sda_t_o, output sda_t_oe_n, input scl, input sda);
endinterface

// ### scma_host.sv
// host end: bus controller issuing one command per request
// assumes the target is the only other party on the wires
`timescale 1ns/1ps
`include "scma_consts.svh"
module scma_host (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // link
    scma_if.host                      bus,
    // request
    input  wire logic                 req_valid,
    input  wire scma_pkg::scma_cmd_type req_cmd,
    input  wire logic [2:0]           req_bus_addr,
    input  wire logic                 req_alt_id,
    input  wire logic                 req_set_ptr,
    input  wire logic [7:0]           req_ptr,
    input  wire logic [7:0]           req_wdata,
    input  wire logic [4:0]           req_len,
    // answer
    output logic                      req_ready,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    output logic                      nack_err
);
    import scma_pkg::*;
    // ****************************************
    // bit engine
    // ****************************************
    typedef enum logic [2:0] {
        SCMA_H_IDLE, SCMA_H_START, SCMA_H_BYTE, SCMA_H_STOP, SCMA_H_DONE
    } scma_hst_type;
    scma_hst_type st_q, st_d;
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic [3:0] bit_q, bit_d, ph_q, ph_d, step_q, step_d;
    logic [7:0] div_q, div_d;
    logic [4:0] left_q, left_d;
    logic       scl_q, scl_d, sda_q, sda_d, rdv_d, err_d, rd_q, rd_d, rs_q, rs_d;
    logic [1:0] sda_s_q, sda_s_d;
    logic       tick;
    logic [7:0] abyte;
    function automatic logic [7:0] addr_byte(input logic reg_sp, input logic alt,
                                             input logic [2:0] ba, input logic rnw);
        addr_byte = {reg_sp ? `SCMA_ID_REG : (alt ? `SCMA_ID_MEM_ALT : `SCMA_ID_MEM), ba, rnw};
    endfunction
    always_comb begin
        tick = (div_q == `SCMA_SCL_HALF);
        abyte = 8'h00;
        sda_s_d = {sda_s_q[0], bus.sda};
        st_d = st_q; tx_d = tx_q; rx_d = rx_q; bit_d = bit_q; ph_d = ph_q; step_d = step_q;
        div_d = tick ? 8'h00 : div_q + 8'h01; left_d = left_q; scl_d = scl_q; sda_d = sda_q;
        rdv_d = 1'b0; err_d = nack_err; rd_d = rd_q; rs_d = rs_q;
        unique case (st_q)
            SCMA_H_IDLE: if (req_valid) begin
                rd_d = (req_cmd == SCMA_CMD_MREAD) || (req_cmd == SCMA_CMD_RREAD);
                rs_d = rd_d & req_set_ptr;
                abyte = addr_byte(req_cmd == SCMA_CMD_RWRITE || req_cmd == SCMA_CMD_RREAD,
                                  req_alt_id, req_bus_addr, rd_d & ~rs_d);
                tx_d = abyte; step_d = 4'h0; left_d = req_len; err_d = 1'b0;
                st_d = SCMA_H_START; ph_d = 4'h0; div_d = 8'h00;
            end
            SCMA_H_START: if (tick) begin
                ph_d = ph_q + 4'h1;
                unique case (ph_q)
                    4'h0: begin sda_d = 1'b1; scl_d = 1'b1; end
                    4'h1: sda_d = 1'b0;
                    default: begin scl_d = 1'b0; st_d = SCMA_H_BYTE; bit_d = 4'h0; ph_d = 4'h0; end
                endcase
            end
            SCMA_H_BYTE: if (tick) begin
                if (!scl_q) begin
                    // data changes in the same cycle that scl is raised
                    if (bit_q < 4'h8) sda_d = (step_q == 4'h2 && rd_q) ? 1'b1 : tx_q[7];
                    else sda_d = (step_q == 4'h2 && rd_q) ? (left_q == 5'h01) : 1'b1;
                    scl_d = 1'b1;
                end else begin
                    scl_d = 1'b0;
                    if (bit_q < 4'h8) begin
                        rx_d = {rx_q[6:0], sda_s_q[1]}; tx_d = {tx_q[6:0], 1'b0};
                        bit_d = bit_q + 4'h1;
                    end else begin
                        bit_d = 4'h0;
                        if (step_q == 4'h2 && rd_q) begin
                            rdv_d = 1'b1; left_d = left_q - 5'h01;
                            if (left_q == 5'h01) st_d = SCMA_H_STOP;
                        end else if (sda_s_q[1]) begin
                            err_d = 1'b1; st_d = SCMA_H_STOP;
                        end else if (step_q == 4'h0) begin
                            step_d = (rd_q && !rs_q) ? 4'h2 : 4'h1;
                            tx_d = req_ptr;
                        end else if (step_q == 4'h1 && rs_q) begin
                            rs_d = 1'b0; step_d = 4'h0; st_d = SCMA_H_START; ph_d = 4'h0;
                            tx_d = addr_byte(req_cmd == SCMA_CMD_RREAD, req_alt_id,
                                             req_bus_addr, 1'b1);
                        end else begin
                            step_d = 4'h2; tx_d = req_wdata;
                            if (step_q == 4'h2) begin
                                left_d = left_q - 5'h01;
                                if (left_q == 5'h01) st_d = SCMA_H_STOP;
                            end
                        end
                    end
                end
            end
            SCMA_H_STOP: if (tick) begin
                ph_d = ph_q + 4'h1;
                unique case (ph_q)
                    4'h0: sda_d = 1'b0;
                    4'h1: scl_d = 1'b1;
                    default: begin sda_d = 1'b1; st_d = SCMA_H_DONE; end
                endcase
            end
            SCMA_H_DONE: st_d = SCMA_H_IDLE;
            default: st_d = SCMA_H_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= SCMA_H_IDLE; tx_q <= 8'h00; rx_q <= 8'h00; bit_q <= 4'h0; ph_q <= 4'h0;
            step_q <= 4'h0; div_q <= 8'h00; left_q <= 5'h00; scl_q <= 1'b1; sda_q <= 1'b1;
            rd_q <= 1'b0; rs_q <= 1'b0; sda_s_q <= 2'h3;
            req_ready <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00; nack_err <= 1'b0;
        end else begin
            st_q <= st_d; tx_q <= tx_d; rx_q <= rx_d; bit_q <= bit_d; ph_q <= ph_d;
            step_q <= step_d; div_q <= div_d; left_q <= left_d; scl_q <= scl_d;
            sda_q <= sda_d; rd_q <= rd_d; rs_q <= rs_d; sda_s_q <= sda_s_d;
            req_ready <= (st_d == SCMA_H_IDLE); rd_valid <= rdv_d; rd_data <= rx_d;
            nack_err <= err_d;
        end
    end
    assign bus.scl_o      = 1'b0;
    assign bus.scl_oe_n   = scl_q;
    assign bus.sda_h_o    = 1'b0;
    assign bus.sda_h_oe_n = sda_q;
endmodule

// ### scma_monitor.sv
// checker for the two-wire link between host end and target end
// assumes the link signals of scma_if, sampled on sys_clk
`timescale 1ns/1ps
module scma_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_t_o,
    input wire logic sda_t_oe_n
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // wire checks
    // ****************************************
    property p_tgt_moves_low; $changed(sda_t_oe_n) |-> !scl; endproperty
    a_tgt_moves_low: assert property (p_tgt_moves_low)
        else $error("target moved sda, scl high");
    property p_drive_before_rise; $fell(sda_t_oe_n) |-> ##[1:12] $rose(scl); endproperty
    a_drive_before_rise: assert property (p_drive_before_rise)
        else $error("late target bit");
    property p_scl_high; $rose(scl) |-> scl [*4]; endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("scl high too short");
    property p_scl_low; $fell(scl) |-> !scl [*4]; endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("scl low too short");
    // target must be idle around framing, else it would corrupt them
    property p_stop_idle; scl && $past(scl) && $rose(sda) |=> sda_t_oe_n [*4]; endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("target drives after stop");
    property p_start_free; scl && $past(scl) && $fell(sda) |-> sda_t_oe_n; endproperty
    a_start_free: assert property (p_start_free)
        else $error("target pulled sda at start");
    property p_no_early_ack; scl && $past(scl) && $fell(sda) |=> sda_t_oe_n [*8]; endproperty
    a_no_early_ack: assert property (p_no_early_ack)
        else $error("target drove in address");
    property p_open_drain; !sda_t_oe_n |-> !sda_t_o; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("target drives sda high");
endmodule

// ### serial_config_memory_access_tb.sv
// testbench: host end and target end joined by the link interface
// assumes the design files and scma_consts.svh are compiled first
`timescale 1ns/1ps
module serial_config_memory_access_tb;
    import scma_pkg::*;
    logic          sys_clk, rst, mr_n, dev_rst, alt_opt, any_opt, req_valid, req_alt_id;
    logic          req_set_ptr, req_ready, rd_valid, nack_err, nv_busy;
    logic [2:0]    strap, req_bus_addr;
    logic [7:0]    req_ptr, req_wdata, rd_data, ptr_out;
    logic [4:0]    req_len;
    scma_cmd_type  req_cmd;
    scma_byte_type rq[$];
    int            fail_count, tests_run;
    scma_if bus ();
    scma_target i_scma_target (.sys_clk(sys_clk), .rst(rst), .bus(bus.target),
        .bus_addr_strap_0(strap[0]), .bus_addr_strap_1(strap[1]), .bus_addr_strap_2(strap[2]),
        .manual_reset_in_n(mr_n), .dev_in_reset(dev_rst), .opt_alt_mem_id(alt_opt),
        .opt_reg_wr_any(any_opt), .nv_busy(nv_busy), .ptr_out(ptr_out));
    scma_host i_scma_host (.sys_clk(sys_clk), .rst(rst), .bus(bus.host), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bus_addr(req_bus_addr), .req_alt_id(req_alt_id),
        .req_set_ptr(req_set_ptr), .req_ptr(req_ptr), .req_wdata(req_wdata), .req_len(req_len),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .nack_err(nack_err));
    scma_monitor i_scma_monitor (.sys_clk(sys_clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
        .sda_t_o(bus.sda_t_o), .sda_t_oe_n(bus.sda_t_oe_n));
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            rq.push_back(rd_data);
        end
    end
    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input scma_cmd_type c, input logic [2:0] ba, input logic alt,
                        input logic sp, input logic [7:0] p, input logic [7:0] d,
                        input logic [4:0] n);
        rq.delete();
        @(posedge sys_clk);
        for (int i = 0; i < 20000 && req_ready !== 1'b1; i++) @(posedge sys_clk);
        req_valid    <= 1'b1;
        req_cmd      <= c;
        req_bus_addr <= ba;
        req_alt_id   <= alt;
        req_set_ptr  <= sp;
        req_ptr      <= p;
        req_wdata    <= d;
        req_len      <= n;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 20000 && req_ready !== 1'b1; i++) @(posedge sys_clk);
        chk("ready", 8'h01, {7'h0, req_ready});
    endtask
    // waits out the commit so later reads see stored data
    task automatic mwr(input logic [7:0] p, input logic [7:0] d, input logic [4:0] n,
                       input logic b);
        xfer(SCMA_CMD_MWRITE, strap, 1'b0, 1'b0, p, d, n);
        // stop reaches the target through its synchroniser a few cycles later
        repeat (4) @(posedge sys_clk);
        chk("commit busy", {7'h0, b}, {7'h0, nv_busy});
        for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++) @(posedge sys_clk);
        chk("commit done", 8'h00, {7'h0, nv_busy});
    endtask
    task automatic rd(input scma_cmd_type c, input logic sp, input logic [7:0] p,
                      input logic [4:0] n, input logic [7:0] e);
        xfer(c, strap, 1'b0, sp, p, 8'h00, n);
        chk("read count", {3'h0, n}, 8'(rq.size()));
        foreach (rq[k]) chk("read byte", e, rq[k]);
    endtask
    task automatic nk(input logic [2:0] ba, input logic alt, input logic e);
        xfer(SCMA_CMD_MREAD, ba, alt, 1'b0, 8'h00, 8'h00, 5'd1);
        chk("nack", {7'h0, e}, {7'h0, nack_err});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {sys_clk, rst, mr_n, dev_rst, alt_opt, any_opt, req_valid} = 7'b0110000;
        {req_alt_id, req_set_ptr, req_bus_addr, req_ptr, req_wdata, req_len} = '0;
        req_cmd = SCMA_CMD_MREAD;
        strap = 3'h5;
        fail_count = 0;
        tests_run = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        mwr(8'h10, 8'h5a, 5'd16, 1'b1);
        rd(SCMA_CMD_MREAD, 1'b1, 8'h10, 5'd15, 8'h5a);
        rd(SCMA_CMD_MREAD, 1'b0, 8'h00, 5'd1, 8'h5a);
        chk("pointer", 8'h1f, ptr_out);
        mwr(8'h30, 8'ha5, 5'd1, 1'b1);
        mr_n <= 1'b0;
        mwr(8'h30, 8'h11, 5'd1, 1'b0);
        rd(SCMA_CMD_MREAD, 1'b1, 8'h30, 5'd1, 8'ha5);
        mr_n <= 1'b1;
        dev_rst <= 1'b1;
        mwr(8'h30, 8'h22, 5'd1, 1'b0);
        dev_rst <= 1'b0;
        rd(SCMA_CMD_MREAD, 1'b1, 8'h30, 5'd1, 8'ha5);
        mr_n <= 1'b0;
        xfer(SCMA_CMD_RWRITE, strap, 1'b0, 1'b0, 8'h04, 8'h44, 5'd1);
        xfer(SCMA_CMD_RWRITE, strap, 1'b0, 1'b0, 8'h03, 8'h3c, 5'd2);
        xfer(SCMA_CMD_RWRITE, strap, 1'b0, 1'b0, 8'h1f, 8'h1f, 5'd1);
        rd(SCMA_CMD_RREAD, 1'b1, 8'h04, 5'd1, 8'h44);
        rd(SCMA_CMD_RREAD, 1'b1, 8'h1f, 5'd1, 8'h1f);
        mr_n <= 1'b1;
        xfer(SCMA_CMD_RWRITE, strap, 1'b0, 1'b0, 8'h03, 8'h77, 5'd1);
        rd(SCMA_CMD_RREAD, 1'b1, 8'h03, 5'd1, 8'h3c);
        any_opt <= 1'b1;
        xfer(SCMA_CMD_RWRITE, strap, 1'b0, 1'b0, 8'h03, 8'h77, 5'd1);
        xfer(SCMA_CMD_RREAD, strap, 1'b0, 1'b1, 8'h03, 8'h00, 5'd2);
        chk("reg first", 8'h77, rq.size() > 0 ? rq[0] : 8'h00);
        chk("reg second", 8'hff, rq.size() > 1 ? rq[1] : 8'h00);
        nk(~strap, 1'b0, 1'b1);
        nk(strap, 1'b1, 1'b1);
        alt_opt <= 1'b1;
        nk(strap, 1'b1, 1'b0);
        nk(strap, 1'b0, 1'b1);
        wrap_up();
    end
    // hang guard, well beyond the expected run of about 17000 cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end
endmodule
